// ### design/iss_pkg.sv
// Package for the status summary block: register map, bit positions, reset values and carrier types.
// Assumes a single clock domain; every user writes iss_pkg::name, nothing is imported.
package iss_pkg;

  // Register bus widths
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // Register indices on the plain register port
  localparam logic [3:0] OFF_EVT_STAT  = 4'h0; // Standard event latches, read clears
  localparam logic [3:0] OFF_EVT_EN    = 4'h1; // Standard event enable
  localparam logic [3:0] OFF_STB       = 4'h2; // Status byte, bit 6 shows master summary
  localparam logic [3:0] OFF_SRQ_EN    = 4'h3; // Service request enable, bit 6 held zero
  localparam logic [3:0] OFF_CLR_ALL   = 4'h4; // Write: clear all event structures
  localparam logic [3:0] OFF_OQ_PUSH   = 4'h5; // Write: put a response byte in the output queue
  localparam logic [3:0] OFF_OQ_POP    = 4'h6; // Read: take the oldest response byte
  localparam logic [3:0] OFF_IRQ_STAT  = 4'h7; // Sticky interrupt causes, read only
  localparam logic [3:0] OFF_IRQ_EN    = 4'h8; // Interrupt enable
  localparam logic [3:0] OFF_IRQ_CLR   = 4'h9; // Write one to clear a cause
  localparam logic [3:0] OFF_OQ_COUNT  = 4'hA; // Output queue fill level

  // Status byte bit positions
  localparam int STB_ESB = 5;
  localparam int STB_MAV = 4;
  localparam int STB_RQS = 6;

  // Standard event bit positions
  localparam int EVT_OPC = 0; // Operation complete
  localparam int EVT_RQC = 1; // Bus control request
  localparam int EVT_QYE = 2; // Query error
  localparam int EVT_DDE = 3; // Device-dependent error
  localparam int EVT_EXE = 4; // Execution error
  localparam int EVT_CME = 5; // Command error
  localparam int EVT_URQ = 6; // User request
  localparam int EVT_PON = 7; // Power on

  // Interrupt cause positions
  localparam int IRQ_ESB  = 0; // Event summary rose
  localparam int IRQ_MAV  = 1; // Message became available
  localparam int IRQ_POLL = 2; // Serial poll served
  localparam int IRQ_OVF  = 3; // Push into a full output queue

  // Reset values and masks
  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic [7:0] MASK_NO_B6 = 8'hBF;
  localparam logic [3:0] RST_IRQ    = 4'h0;

  // Register bus request as one carrier
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              we;
    logic              re;
  } iss_bus_req_t;

  // Service request states, one-hot
  typedef enum logic [2:0] {
    RQ_IDLE   = 3'b001,
    RQ_PEND   = 3'b010,
    RQ_SERVED = 3'b100
  } iss_rq_state_t;

endpackage : iss_pkg

// ### design/iss_event_reg.sv
// Register-model cell: sticky event latches, an enable register and their OR summary.
// Assumes set pulses come from logic on clk; the owner decides when read and clear happen.
module iss_event_reg #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             ce,
  // Event sources and clearing
  input  wire logic [WIDTH-1:0] evt_set,
  input  wire logic             evt_clr,
  // Enable register write
  input  wire logic             en_we,
  input  wire logic [WIDTH-1:0] en_wdata,
  // State seen by the owner
  output logic      [WIDTH-1:0] evt_q,
  output logic      [WIDTH-1:0] en_q,
  output logic                  summary
);

  logic [WIDTH-1:0] evt_d;
  logic [WIDTH-1:0] en_d;
  logic [WIDTH-1:0] masked;

  // Latches hold until cleared; a set in the clear cycle survives
  always_comb begin
    evt_d = evt_q;
    en_d  = en_q;
    if (ce) begin
      evt_d = (evt_clr ? '0 : evt_q) | evt_set;
      if (en_we) begin
        en_d = en_wdata;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      evt_q <= '0;
      en_q  <= '0;
    end else begin
      evt_q <= evt_d;
      en_q  <= en_d;
    end
  end

  // Per-bit AND, then OR into one summary
  assign masked  = evt_q & en_q;
  assign summary = |masked;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_evt_sticky: assert property (ce && !evt_clr |=> (evt_q & $past(evt_q)) == $past(evt_q))
    else $error("event latch dropped without a clear");
  a_evt_set_wins: assert property (ce && evt_clr |=> evt_q == $past(evt_set))
    else $error("clear did not leave exactly the new events");
  a_summary_or: assert property (summary == (|(evt_q & en_q)))
    else $error("summary is not the OR of enabled events");

endmodule : iss_event_reg

// ### design/iss_status_summary.sv
// Status summary block: standard event register, output queue, status byte and service request.
// Assumes events, queue pushes and the register port come from logic on clk; the poll pin is asynchronous.
//
// What this block does
// - Each register-model bit is one where event and its enable are both one.
// - A register-model summary is the OR of all its masked bits.
// - The queue summary is one while the queue holds any entry, else zero.
// - Standard event register has eight bits, power on through operation complete.
// - Status byte bit 5 is the masked summary of the standard event register.
// - Status byte bit 4 shows an unread entry waiting in the output queue.
// - The status byte is built from seven summary bits of the structures.
// - Service request is raised when status byte masked by its enable is nonzero.
// - Polled status byte bit 6 carries the request flag; a register read of the status byte shows master summary there.
// - A serial poll clears the request flag at once until a new cause.
// - Bit 6 of status byte and request enable count as zero for master summary.
//
// Local design decisions: the strobed register port and the register addresses.
module iss_status_summary #(
  parameter int OQ_DEPTH = 8
) (
  // Clock, reset and clock enable
  input  wire logic                       clk,
  input  wire logic                       nrst,
  input  wire logic                       ce,
  // Register port
  input  wire iss_pkg::iss_bus_req_t      bus_req,
  output logic [iss_pkg::DATA_W-1:0]      rdata_q,
  // Event sources
  input  wire logic [7:0]                 std_evt,
  input  wire logic [4:0]                 dev_sum,
  // Controller side
  input  wire logic                       poll_pin,
  output logic                            srq_q,
  output logic [7:0]                      poll_byte_q,
  output logic                            poll_valid_q,
  // Interrupt
  output logic                            irq_q
);

  localparam int CNT_W = $clog2(OQ_DEPTH + 1);
  localparam int PTR_W = (OQ_DEPTH > 1) ? $clog2(OQ_DEPTH) : 1;

  // Register decode used by several processes
  function automatic logic hit(input iss_pkg::iss_bus_req_t r, input logic [3:0] off, input logic wr);
    hit = (wr ? r.we : r.re) && (r.addr == off);
  endfunction : hit

  // Standard event register and enable
  logic [7:0] esr;
  logic [7:0] ese;
  logic       esb;
  logic       clr_all;

  assign clr_all = hit(bus_req, iss_pkg::OFF_CLR_ALL, 1'b1);

  iss_event_reg #(
    .WIDTH (8)
  ) u_std_evt (
    .clk      (clk),
    .nrst     (nrst),
    .ce       (ce),
    .evt_set  (std_evt),
    .evt_clr  (clr_all || hit(bus_req, iss_pkg::OFF_EVT_STAT, 1'b0)),
    .en_we    (hit(bus_req, iss_pkg::OFF_EVT_EN, 1'b1)),
    .en_wdata (bus_req.wdata),
    .evt_q    (esr),
    .en_q     (ese),
    .summary  (esb)
  );

  // Output queue
  logic [7:0]       oq_mem [OQ_DEPTH];
  logic [PTR_W-1:0] oq_wp_q, oq_wp_d, oq_rp_q, oq_rp_d;
  logic [CNT_W-1:0] oq_cnt_q, oq_cnt_d;
  logic             oq_push, oq_pop, oq_full, oq_empty, oq_ovf;

  assign oq_full  = (oq_cnt_q == CNT_W'(OQ_DEPTH));
  assign oq_empty = (oq_cnt_q == '0);
  assign oq_push  = ce && hit(bus_req, iss_pkg::OFF_OQ_PUSH, 1'b1) && !oq_full;
  assign oq_pop   = ce && hit(bus_req, iss_pkg::OFF_OQ_POP, 1'b0) && !oq_empty;
  assign oq_ovf   = ce && hit(bus_req, iss_pkg::OFF_OQ_PUSH, 1'b1) && oq_full;

  // Queue pointers; clearing events leaves unread responses in place
  always_comb begin
    oq_wp_d  = oq_wp_q;
    oq_rp_d  = oq_rp_q;
    oq_cnt_d = oq_cnt_q;
    if (oq_push) begin
      oq_wp_d = (oq_wp_q == PTR_W'(OQ_DEPTH - 1)) ? '0 : oq_wp_q + 1'b1;
    end
    if (oq_pop) begin
      oq_rp_d = (oq_rp_q == PTR_W'(OQ_DEPTH - 1)) ? '0 : oq_rp_q + 1'b1;
    end
    case ({oq_push, oq_pop})
      2'b10:   oq_cnt_d = oq_cnt_q + 1'b1;
      2'b01:   oq_cnt_d = oq_cnt_q - 1'b1;
      default: oq_cnt_d = oq_cnt_q;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      oq_wp_q  <= '0;
      oq_rp_q  <= '0;
      oq_cnt_q <= '0;
    end else begin
      oq_wp_q  <= oq_wp_d;
      oq_rp_q  <= oq_rp_d;
      oq_cnt_q <= oq_cnt_d;
    end
  end

  // Storage has no reset; entries are only read behind the count
  always_ff @(posedge clk) begin
    if (oq_push) begin
      oq_mem[oq_wp_q] <= bus_req.wdata;
    end
  end

  // Status byte assembly
  logic       mav;
  logic [7:0] stb_sum;
  logic [7:0] sre_q, sre_d;
  logic [7:0] masked_stb, masked_prev_q;
  logic       mss, new_cause;

  assign mav = !oq_empty;

  // Seven summaries; bit 6 left zero for the request flag
  assign stb_sum = {dev_sum[4], 1'b0, esb, mav, dev_sum[3:0]};

  // Enable keeps bit 6 at zero so it never takes part
  always_comb begin
    sre_d = sre_q;
    if (ce && hit(bus_req, iss_pkg::OFF_SRQ_EN, 1'b1)) begin
      sre_d = bus_req.wdata & iss_pkg::MASK_NO_B6;
    end
  end

  assign masked_stb = stb_sum & sre_q & iss_pkg::MASK_NO_B6;
  assign mss        = |masked_stb;
  assign new_cause  = |(masked_stb & ~masked_prev_q);

  // Poll pin synchroniser; edge detect reads only the second and third stages
  logic poll_s1_q, poll_s2_q, poll_s3_q, poll_edge;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      poll_s1_q <= 1'b0;
      poll_s2_q <= 1'b0;
      poll_s3_q <= 1'b0;
    end else if (ce) begin
      poll_s1_q <= poll_pin;
      poll_s2_q <= poll_s1_q;
      poll_s3_q <= poll_s2_q;
    end
  end

  assign poll_edge = ce && poll_s2_q && !poll_s3_q;

  // Request flag: raised on a cause, dropped by a poll, re-armed only by a new cause
  iss_pkg::iss_rq_state_t rq_q, rq_d;
  logic                   rqs;

  always_comb begin
    rq_d = rq_q;
    if (ce) begin
      case (rq_q)
        iss_pkg::RQ_IDLE: begin
          if (mss) rq_d = iss_pkg::RQ_PEND;
        end
        iss_pkg::RQ_PEND: begin
          if (poll_edge)  rq_d = iss_pkg::RQ_SERVED;
          else if (!mss)  rq_d = iss_pkg::RQ_IDLE;
        end
        iss_pkg::RQ_SERVED: begin
          if (!mss)           rq_d = iss_pkg::RQ_IDLE;
          else if (new_cause) rq_d = iss_pkg::RQ_PEND;
        end
        default: rq_d = iss_pkg::RQ_IDLE;
      endcase
    end
  end

  assign rqs = (rq_q == iss_pkg::RQ_PEND);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rq_q          <= iss_pkg::RQ_IDLE;
      sre_q         <= iss_pkg::RST_BYTE;
      masked_prev_q <= iss_pkg::RST_BYTE;
    end else begin
      rq_q          <= rq_d;
      sre_q         <= sre_d;
      masked_prev_q <= ce ? masked_stb : masked_prev_q;
    end
  end

  // Interrupt causes: set wins over a clear in the same cycle
  logic [3:0] ist_q, ist_d, ien_q, ien_d, ist_set;
  logic       esb_prev_q, mav_prev_q;

  assign ist_set = {oq_ovf, poll_edge && rqs, ce && mav && !mav_prev_q, ce && esb && !esb_prev_q};

  always_comb begin
    ist_d = ist_q;
    ien_d = ien_q;
    if (ce) begin
      if (hit(bus_req, iss_pkg::OFF_IRQ_CLR, 1'b1)) ist_d = ist_q & ~bus_req.wdata[3:0];
      if (hit(bus_req, iss_pkg::OFF_IRQ_EN, 1'b1))  ien_d = bus_req.wdata[3:0];
    end
    ist_d = ist_d | ist_set;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ist_q      <= iss_pkg::RST_IRQ;
      ien_q      <= iss_pkg::RST_IRQ;
      esb_prev_q <= 1'b0;
      mav_prev_q <= 1'b0;
    end else begin
      ist_q      <= ist_d;
      ien_q      <= ien_d;
      esb_prev_q <= ce ? esb : esb_prev_q;
      mav_prev_q <= ce ? mav : mav_prev_q;
    end
  end

  // Read mux; status byte read shows master summary at bit 6
  logic [7:0] rdata_d;

  always_comb begin
    rdata_d = rdata_q;
    if (ce) begin
      rdata_d = iss_pkg::RST_BYTE;
      if (bus_req.re) begin
        case (bus_req.addr)
          iss_pkg::OFF_EVT_STAT: rdata_d = esr;
          iss_pkg::OFF_EVT_EN:   rdata_d = ese;
          iss_pkg::OFF_STB:      rdata_d = stb_sum | {1'b0, mss, 6'h00};
          iss_pkg::OFF_SRQ_EN:   rdata_d = sre_q;
          iss_pkg::OFF_OQ_POP:   rdata_d = oq_empty ? iss_pkg::RST_BYTE : oq_mem[oq_rp_q];
          iss_pkg::OFF_IRQ_STAT: rdata_d = {4'h0, ist_q};
          iss_pkg::OFF_IRQ_EN:   rdata_d = {4'h0, ien_q};
          iss_pkg::OFF_OQ_COUNT: rdata_d = 8'(oq_cnt_q);
          default:               rdata_d = iss_pkg::RST_BYTE;
        endcase
      end
    end
  end

  // Output registers; poll byte is captured on the poll with the flag before it drops
  logic [7:0] poll_byte_d;
  logic       poll_valid_d, srq_d, irq_d;

  always_comb begin
    poll_byte_d  = poll_byte_q;
    poll_valid_d = poll_valid_q;
    srq_d        = srq_q;
    irq_d        = irq_q;
    if (ce) begin
      poll_valid_d = poll_edge;
      if (poll_edge) poll_byte_d = stb_sum | {1'b0, rqs, 6'h00};
      srq_d = rqs;
      irq_d = |(ist_q & ien_q);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q      <= iss_pkg::RST_BYTE;
      poll_byte_q  <= iss_pkg::RST_BYTE;
      poll_valid_q <= 1'b0;
      srq_q        <= 1'b0;
      irq_q        <= 1'b0;
    end else begin
      rdata_q      <= rdata_d;
      poll_byte_q  <= poll_byte_d;
      poll_valid_q <= poll_valid_d;
      srq_q        <= srq_d;
      irq_q        <= irq_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_esb_bit_five: assert property (stb_sum[iss_pkg::STB_ESB] == (|(esr & ese)))
    else $error("status byte bit 5 differs from masked event summary");
  a_mav_queue: assert property (stb_sum[iss_pkg::STB_MAV] == (oq_cnt_q != '0))
    else $error("message available does not follow queue occupancy");
  a_srq_raise: assert property (ce && rq_q == iss_pkg::RQ_IDLE && mss ##1 ce |=> srq_q)
    else $error("service request not raised two cycles after cause");
  a_poll_clears: assert property (poll_edge && rqs |=> !rqs ##1 !srq_q)
    else $error("request flag survived a serial poll");
  a_bit_six_out: assert property (!sre_q[iss_pkg::STB_RQS] && !stb_sum[iss_pkg::STB_RQS]
                                  && mss == (|{stb_sum[7] & sre_q[7], stb_sum[5:0] & sre_q[5:0]}))
    else $error("bit 6 took part in master summary");
  a_poll_byte: assert property (poll_edge |=> poll_valid_q && poll_byte_q[6] == $past(rqs))
    else $error("poll byte bit 6 is not the request flag");
  a_stb_read: assert property (ce && hit(bus_req, iss_pkg::OFF_STB, 1'b0)
                               |=> rdata_q == ($past(stb_sum) | {1'b0, $past(mss), 6'h00}))
    else $error("status byte read returned the wrong value");
  a_clear_all: assert property (ce && clr_all |=> esr == $past(std_evt))
    else $error("clear left stale standard events");

  c_poll_served:  cover property (rqs ##1 poll_edge ##1 rq_q == iss_pkg::RQ_SERVED);
  c_mav_request:  cover property (oq_push && sre_q[iss_pkg::STB_MAV] ##[1:4] srq_q);
  c_queue_full:   cover property (oq_full ##1 oq_ovf);
  c_irq_raised:   cover property (!irq_q ##1 irq_q);

endmodule : iss_status_summary

// ### tb/iss_ctrl_model.sv
// Bus controller model: raises the serial poll line and captures the answered byte.
// Assumes the block registers its poll answer on clk and syncs the poll line itself.
module iss_ctrl_model (
  // Clock
  input  wire logic       clk,
  // Poll answer from the block
  input  wire logic [7:0] poll_byte,
  input  wire logic       poll_valid,
  // Poll line toward the block
  output logic            poll_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  // Poll line idles low from time zero
  initial poll_pin = 1'b0;

  // One poll; each level is held several cycles so the sync stages cannot miss it
  task automatic do_poll(output logic [7:0] b, output logic seen);
    int n;
    seen = 1'b0;
    b = 8'h00;
    @(posedge clk) poll_pin <= 1'b1;
    for (n = 0; n < 12; n++) begin
      @(posedge clk);
      #1;
      if (!seen && poll_valid === 1'b1) begin
        seen = 1'b1;
        b = poll_byte;
      end
    end
    @(posedge clk) poll_pin <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : do_poll
endmodule : iss_ctrl_model

// ### tb/ieee4882_status_summary_bench.sv
// Self-checking bench for the status summary block: register port tasks and a poll model.
// Assumes the register map and bit positions of iss_pkg and a 4 ns clock.
module ieee4882_status_summary_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic                 clk;
  logic                 nrst;
  logic                 ce;
  iss_pkg::iss_bus_req_t bus_req;
  logic [7:0]           rdata_q;
  logic [7:0]           std_evt;
  logic [4:0]           dev_sum;
  logic                 poll_pin;
  logic                 srq_q;
  logic [7:0]           poll_byte_q;
  logic                 poll_valid_q;
  logic                 irq_q;
  logic [7:0]           pb;
  logic                 pseen;
  int                   n_errors;
  int                   samples_checked;

  iss_status_summary #(.OQ_DEPTH(8)) iss_status_summary_inst (
    .clk(clk), .nrst(nrst), .ce(ce), .bus_req(bus_req), .rdata_q(rdata_q), .std_evt(std_evt),
    .dev_sum(dev_sum), .poll_pin(poll_pin), .srq_q(srq_q), .poll_byte_q(poll_byte_q),
    .poll_valid_q(poll_valid_q), .irq_q(irq_q));

  iss_ctrl_model iss_ctrl_model_inst (
    .clk(clk), .poll_byte(poll_byte_q), .poll_valid(poll_valid_q), .poll_pin(poll_pin));

  // Clock at 250 MHz
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Compare and count; unknowns never match
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk) bus_req <= {a, d, 1'b1, 1'b0};
    @(posedge clk) bus_req <= '0;
  endtask : wr

  // One-cycle read strobe; data stand only in the following cycle
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk) bus_req <= {a, 8'h00, 1'b0, 1'b1};
    @(posedge clk) bus_req <= '0;
    #1;
    chk(rdata_q, exp);
  endtask : rd

  // One-cycle event pulse
  task automatic evt(input logic [7:0] e);
    @(posedge clk) std_evt <= e;
    @(posedge clk) std_evt <= 8'h00;
  endtask : evt

  // Verdict in one place
  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim

  // Watchdog well beyond the expected run of a few hundred cycles
  initial begin
    #40000;
    n_errors++;
    end_sim();
  end

  // Main sequence
  initial begin
    n_errors = 0;
    samples_checked = 0;
    nrst = 1'b0;
    ce = 1'b1;
    bus_req = '0;
    std_evt = 8'h00;
    dev_sum = 5'h00;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    #1;
    chk({7'h00, srq_q}, 8'h00);
    chk({7'h00, irq_q}, 8'h00);
    rd(iss_pkg::OFF_STB, 8'h00);
    rd(4'hF, 8'h00); // Unmapped read
    // Masked event gives no summary, enabling it afterwards does
    evt(8'h80);
    rd(iss_pkg::OFF_STB, 8'h00);
    wr(iss_pkg::OFF_EVT_EN, 8'h80);
    rd(iss_pkg::OFF_EVT_EN, 8'h80);
    rd(iss_pkg::OFF_STB, 8'h20);
    rd(iss_pkg::OFF_EVT_STAT, 8'h80);
    // Every event bit latches and feeds the summary through its own enable
    for (int i = 0; i < 8; i++) begin
      wr(iss_pkg::OFF_EVT_EN, 8'h01 << i);
      evt(8'hFF ^ (8'h01 << i));
      rd(iss_pkg::OFF_STB, 8'h00);
      evt(8'h01 << i);
      rd(iss_pkg::OFF_STB, 8'h20);
      wr(iss_pkg::OFF_CLR_ALL, 8'h00);
      rd(iss_pkg::OFF_EVT_STAT, 8'h00);
    end
    wr(iss_pkg::OFF_STB, 8'hFF); // Read-only place, write ignored
    rd(iss_pkg::OFF_STB, 8'h00);
    // Queue summary follows fill level
    wr(iss_pkg::OFF_OQ_PUSH, 8'hA5);
    rd(iss_pkg::OFF_STB, 8'h10);
    rd(iss_pkg::OFF_OQ_POP, 8'hA5);
    rd(iss_pkg::OFF_STB, 8'h00);
    rd(iss_pkg::OFF_OQ_POP, 8'h00);
    // Seven summaries, request enable with bit 6 ignored
    @(posedge clk) dev_sum <= 5'h1F;
    wr(iss_pkg::OFF_OQ_PUSH, 8'h3C);
    wr(iss_pkg::OFF_EVT_EN, 8'h01);
    evt(8'h01);
    rd(iss_pkg::OFF_STB, 8'hBF);
    wr(iss_pkg::OFF_SRQ_EN, 8'h40);
    rd(iss_pkg::OFF_SRQ_EN, 8'h00);
    repeat (4) @(posedge clk);
    #1;
    chk({7'h00, srq_q}, 8'h00);
    wr(iss_pkg::OFF_SRQ_EN, 8'h10);
    repeat (3) @(posedge clk);
    #1;
    chk({7'h00, srq_q}, 8'h01);
    rd(iss_pkg::OFF_STB, 8'hFF);
    iss_ctrl_model_inst.do_poll(pb, pseen);
    chk({7'h00, pseen}, 8'h01);
    chk(pb, 8'hFF);
    chk({7'h00, srq_q}, 8'h00);
    iss_ctrl_model_inst.do_poll(pb, pseen);
    chk(pb, 8'hBF);
    chk({7'h00, pseen}, 8'h01);
    chk({7'h00, srq_q}, 8'h00);
    // A newly enabled cause re-arms the request after the poll
    wr(iss_pkg::OFF_SRQ_EN, 8'h30);
    repeat (3) @(posedge clk);
    #1;
    chk({7'h00, srq_q}, 8'h01);
    // Interrupt causes: summary rose, message rose, poll served
    rd(iss_pkg::OFF_IRQ_STAT, 8'h07);
    chk({7'h00, irq_q}, 8'h00);
    wr(iss_pkg::OFF_IRQ_EN, 8'h02);
    @(posedge clk);
    #1;
    chk({7'h00, irq_q}, 8'h01);
    rd(iss_pkg::OFF_IRQ_EN, 8'h02);
    wr(iss_pkg::OFF_IRQ_CLR, 8'h02);
    @(posedge clk);
    #1;
    chk({7'h00, irq_q}, 8'h00);
    rd(iss_pkg::OFF_IRQ_STAT, 8'h05);
    // Fill queue until refused, overflow cause set
    for (int i = 0; i < 8; i++) begin
      wr(iss_pkg::OFF_OQ_PUSH, 8'h10 + 8'(i));
    end
    rd(iss_pkg::OFF_OQ_COUNT, 8'h08);
    rd(iss_pkg::OFF_IRQ_STAT, 8'h0D);
    rd(iss_pkg::OFF_OQ_POP, 8'h3C);
    // Clock enable low freezes state: a write and an event are both ignored
    @(posedge clk) ce <= 1'b0;
    wr(iss_pkg::OFF_SRQ_EN, 8'h00);
    evt(8'h02);
    @(posedge clk) ce <= 1'b1;
    rd(iss_pkg::OFF_SRQ_EN, 8'h30);
    rd(iss_pkg::OFF_EVT_STAT, 8'h01);
    end_sim();
  end
endmodule : ieee4882_status_summary_bench
